//--- core/ssr_pkg.sv
package ssr_pkg;

    // Register addresses on the internal register access port.
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h93;
    localparam logic [7:0] ADDR_CLEAR_LOW = 8'h94;
    localparam logic [7:0] ADDR_CLEAR_HIGH = 8'h95;
    localparam logic [7:0] ADDR_RED_LOW = 8'h96;
    localparam logic [7:0] ADDR_RED_HIGH = 8'h97;
    localparam logic [7:0] ADDR_GREEN_LOW = 8'h98;
    localparam logic [7:0] ADDR_GREEN_HIGH = 8'h99;
    localparam logic [7:0] ADDR_BLUE_LOW = 8'h9A;
    localparam logic [7:0] ADDR_BLUE_HIGH = 8'h9B;
    localparam logic [7:0] ADDR_PROX_LOW = 8'h9C;
    localparam logic [7:0] ADDR_PROX_HIGH = 8'h9D;
    localparam logic [7:0] ADDR_VALID_SAT = 8'h9E;

    // Event status bit positions.
    localparam int ST_COLOR_SAT = 7;
    localparam int ST_PROX_SAT = 6;
    localparam int ST_PROX_EVENT = 5;
    localparam int ST_COLOR_EVENT = 4;
    localparam int ST_GESTURE = 2;
    localparam int ST_CALIB = 1;
    localparam logic [7:0] EVENT_STATUS_MASK = 8'hF6;

    // Validity and saturation status bit positions.
    localparam int S2_PROX_VALID = 7;
    localparam int S2_COLOR_VALID = 6;
    localparam int S2_COUNTER_SAT = 4;
    localparam int S2_FRONTEND_SAT = 3;
    localparam int S2_CONVERTER_SAT = 2;
    localparam int S2_REFLECTED_SAT = 1;
    localparam int S2_AMBIENT_SAT = 0;

    // Reset values.
    localparam logic [7:0] EVENT_STATUS_RESET = 8'h00;
    localparam logic [4:0] SAT_RESET = 5'h00;
    localparam logic [2:0] APC_SHIFT_RESET = 3'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Pulse control: shift 0 means 16 pulses, shift 4 means one pulse.
    localparam logic [2:0] APC_SHIFT_MAX = 3'h4;
    localparam logic [9:0] APC_HIGH_MARK = 10'h300;
    localparam logic [9:0] APC_LOW_MARK = 10'h0C0;
    localparam logic [4:0] APC_FULL_PULSES = 5'h10;

    // Reciprocal of three, scaled by two to the seventeenth.
    localparam logic [16:0] DIV3_FACTOR = 17'h0AAAB;
    localparam int DIV3_SHIFT = 17;

    // Static configuration seen by the block.
    typedef struct packed {
        logic prox_sat_irq_en;
        logic color_sat_irq_en;
        logic prox_irq_en;
        logic gesture_irq_en;
        logic prox_engine_en;
        logic color_engine_en;
        logic route_ir_diodes_to_color;
        logic [2:0] calib_func_en;
        logic [3:0] prox_diode_mask;
    } ssr_config_type;

    // Colour engine results and events.
    typedef struct packed {
        logic [3:0][15:0] color;
        logic [3:0][15:0] ir;
        logic cycle_done;
        logic counter_saturated;
        logic frontend_saturated;
        logic threshold_event;
    } ssr_color_in_type;

    // Proximity engine results and events.
    typedef struct packed {
        logic [3:0][9:0] adc;
        logic cycle_done;
        logic converter_saturated;
        logic reflected_saturated;
        logic ambient_saturated;
        logic threshold_event;
    } ssr_prox_in_type;

    // Gesture queue and calibration events.
    typedef struct packed {
        logic [5:0] queue_level;
        logic [5:0] queue_threshold;
        logic queue_read;
        logic data_valid;
        logic mode_active;
        logic calib_done;
        logic [2:0] calib_event;
    } ssr_misc_in_type;

    // Complete state of the register bank.
    typedef struct packed {
        logic [7:0] event_status;
        logic prox_valid;
        logic color_valid;
        logic [4:0] sat;
        logic [3:0][15:0] live_color;
        logic [3:0][15:0] latch_color;
        logic [13:0] prox_result;
        logic [2:0] apc_shift;
        logic gesture_mode_q;
        logic prox_en_q;
        logic color_en_q;
        logic [7:0] rdata;
    } ssr_state_type;

endpackage

//--- core/ssr_status_regs.sv
// Function
// RULE1: Event status byte read-only, bits 3,0 reserved.
// RULE2: Colour saturation sets bit 7 when enabled.
// RULE3: Proximity analog saturation sets bit 6 when enabled.
// RULE4: Proximity threshold event sets bit 5 when enabled.
// RULE5: Colour threshold event sets bit 4 when enabled.
// RULE6: Gesture queue level or valid-at-exit sets bit 2.
// RULE7: Gesture bit clears when queue read empty.
// RULE8: Calibration done or enabled events set bit 1.
// RULE9: Host reads colour pairs low then high.
// RULE10: Clear low byte read latches all colour bytes.
// RULE11: Colour block order clear, red, green, blue.
// RULE12: Proximity result 14 bits over two bytes.
// RULE13: Result is converter value times 16/pulses.
// RULE14: Fewer emitter pulses as reflected signal grows.
// RULE15: Result averages only unmasked proximity diodes.
// RULE16: Proximity valid since enable or result read.
// RULE17: Colour valid since enable or clear read.
// RULE18: Second status bit 4 flags counter saturation.
// RULE19: Second status bit 3 flags front-end saturation.
// RULE20: Second status bit 2 flags converter maximum.
// RULE21: Bits 1,0 flag reflected, ambient saturation.
// RULE22: Saturation enables come from configuration bits 7,6.
// RULE23: Route bit swaps colour data for infrared diodes.
// RULE24: Reserved bits read zero, writes ignored.
// RULE25: Valid flags clear on their low byte read.
module ssr_status_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire ssr_pkg::ssr_config_type cfg,
    input wire ssr_pkg::ssr_color_in_type color_in,
    input wire ssr_pkg::ssr_prox_in_type prox_in,
    input wire ssr_pkg::ssr_misc_in_type misc_in,
    input wire logic [7:0] status_clear,
    output logic [7:0] event_status,
    output logic [4:0] prox_pulse_count
);

    ssr_pkg::ssr_state_type state_q;
    ssr_pkg::ssr_state_type state_d;

    logic [11:0] diode_sum;
    logic [2:0] diode_count;
    logic [9:0] diode_avg;
    logic [28:0] div3_product;
    logic [13:0] scaled_result;
    logic [7:0] event_set;
    logic [7:0] event_clr;
    logic [4:0] sat_set;
    logic gesture_level_hit;
    logic gesture_exit_hit;
    logic gesture_drained;
    logic rd_clear_low;
    logic rd_prox_low;
    logic rd_valid_sat;
    logic [7:0] validity_saturation_status_byte;

    ////////////////////////////////////////////////////////////////////////
    // Proximity normalisation.

    // Sum and count only the diodes whose mask bit is clear.
    always_comb begin
        diode_sum = 12'h000;
        diode_count = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (!cfg.prox_diode_mask[i]) begin // see RULE15
                diode_sum = diode_sum + {2'h0, prox_in.adc[i]};
                diode_count = diode_count + 3'h1;
            end
        end
    end

    // Dividing by the active count keeps the scale independent of masking.
    assign div3_product = {5'h00, diode_sum} * {12'h000, ssr_pkg::DIV3_FACTOR};

    // Average of the active diodes; all masked gives zero.
    always_comb begin
        unique case (diode_count)
            3'h1: diode_avg = diode_sum[9:0]; // see RULE15
            3'h2: diode_avg = diode_sum[10:1]; // see RULE15
            3'h3: diode_avg = div3_product[26:17]; // see RULE15
            3'h4: diode_avg = diode_sum[11:2]; // see RULE15
            default: diode_avg = 10'h000;
        endcase
    end

    // Fewer pulses means a larger factor: 16/pulses equals 2 to the shift.
    assign scaled_result =
        14'({4'h0, diode_avg} << state_q.apc_shift); // see RULE13

    // Number of pulses requested from the emitter for the next cycle.
    assign prox_pulse_count =
        5'(ssr_pkg::APC_FULL_PULSES >> state_q.apc_shift); // see RULE14

    ////////////////////////////////////////////////////////////////////////
    // Read strobes with side effects.

    // Decode of the reads that clear or latch something.
    assign rd_clear_low = reg_rd && (reg_addr == ssr_pkg::ADDR_CLEAR_LOW);
    assign rd_prox_low = reg_rd && (reg_addr == ssr_pkg::ADDR_PROX_LOW);
    assign rd_valid_sat = reg_rd && (reg_addr == ssr_pkg::ADDR_VALID_SAT);

    // Address falls inside the bank.
    assign reg_hit = (reg_addr >= ssr_pkg::ADDR_EVENT_STATUS) &&
                     (reg_addr <= ssr_pkg::ADDR_VALID_SAT);

    ////////////////////////////////////////////////////////////////////////
    // Event status set and clear terms.

    // Gesture: queue above its threshold, or valid as gesture mode ends.
    assign gesture_level_hit = (misc_in.queue_level != 6'h00) &&
        (misc_in.queue_level > misc_in.queue_threshold); // see RULE6
    assign gesture_exit_hit = misc_in.data_valid &&
        state_q.gesture_mode_q && !misc_in.mode_active; // see RULE6

    // The read that takes the last queued entry drains the queue.
    assign gesture_drained = misc_in.queue_read &&
        (misc_in.queue_level == 6'h01); // see RULE7

    // Set terms, each gated by its enable except calibration done.
    always_comb begin
        event_set = 8'h00;
        event_set[ssr_pkg::ST_COLOR_SAT] =
            cfg.color_sat_irq_en && // see RULE22
            (color_in.counter_saturated ||
             color_in.frontend_saturated); // see RULE2
        event_set[ssr_pkg::ST_PROX_SAT] = cfg.prox_sat_irq_en && // see RULE22
            (prox_in.reflected_saturated ||
             prox_in.ambient_saturated); // see RULE3
        event_set[ssr_pkg::ST_PROX_EVENT] = cfg.prox_irq_en &&
            prox_in.threshold_event; // see RULE4
        event_set[ssr_pkg::ST_COLOR_EVENT] = cfg.color_sat_irq_en &&
            color_in.threshold_event; // see RULE5
        event_set[ssr_pkg::ST_GESTURE] = cfg.gesture_irq_en &&
            (gesture_level_hit || gesture_exit_hit); // see RULE6
        event_set[ssr_pkg::ST_CALIB] = misc_in.calib_done ||
            |(misc_in.calib_event & cfg.calib_func_en); // see RULE8
    end

    // Clear terms: an outside clear pulse, and the drained gesture queue.
    always_comb begin
        event_clr = status_clear;
        event_clr[ssr_pkg::ST_GESTURE] = status_clear[ssr_pkg::ST_GESTURE] ||
            gesture_drained; // see RULE7
    end

    // Saturation detail bits in second-status order 4 down to 0.
    assign sat_set = {color_in.counter_saturated, // see RULE18
                      color_in.frontend_saturated, // see RULE19
                      prox_in.converter_saturated, // see RULE20
                      prox_in.reflected_saturated, // see RULE21
                      prox_in.ambient_saturated}; // see RULE21

    // Second status byte with bit 5 reserved as zero.
    always_comb begin
        validity_saturation_status_byte = 8'h00; // see RULE24
        validity_saturation_status_byte[ssr_pkg::S2_PROX_VALID] = state_q.prox_valid;
        validity_saturation_status_byte[ssr_pkg::S2_COLOR_VALID] = state_q.color_valid;
        validity_saturation_status_byte[4:0] = state_q.sat;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    // Every flag lets a set in the same cycle win over its clear.
    always_comb begin
        state_d = state_q;
        state_d.gesture_mode_q = misc_in.mode_active;
        state_d.prox_en_q = cfg.prox_engine_en;
        state_d.color_en_q = cfg.color_engine_en;

        // Sticky event bits; reserved bits are forced low.
        state_d.event_status = ((state_q.event_status & ~event_clr) |
            event_set) & ssr_pkg::EVENT_STATUS_MASK; // see RULE1

        // Saturation detail bits clear when the second status is read.
        if (rd_valid_sat) begin
            state_d.sat = sat_set;
        end else begin
            state_d.sat = state_q.sat | sat_set;
        end

        // Proximity valid: cleared on enable rise or result read.
        if (cfg.prox_engine_en && !state_q.prox_en_q) begin
            state_d.prox_valid = 1'b0; // see RULE16
        end
        if (rd_prox_low) begin
            state_d.prox_valid = 1'b0; // see RULE25
        end
        if (prox_in.cycle_done && cfg.prox_engine_en) begin
            state_d.prox_valid = 1'b1; // see RULE16
        end

        // Colour valid: cleared on enable rise or clear low read.
        if (cfg.color_engine_en && !state_q.color_en_q) begin
            state_d.color_valid = 1'b0; // see RULE17
        end
        if (rd_clear_low) begin
            state_d.color_valid = 1'b0; // see RULE25
        end
        if (color_in.cycle_done && cfg.color_engine_en) begin
            state_d.color_valid = 1'b1; // see RULE17
        end

        // Live colour data follows the engine, or the infrared diodes.
        if (color_in.cycle_done) begin
            if (cfg.route_ir_diodes_to_color) begin
                state_d.live_color = color_in.ir; // see RULE23
            end else begin
                state_d.live_color = color_in.color; // see RULE11
            end
        end

        // A clear low read freezes all eight bytes of one measurement.
        if (rd_clear_low) begin
            state_d.latch_color = state_q.live_color; // see RULE10
        end

        // Proximity result and pulse control update at cycle end.
        if (prox_in.cycle_done) begin
            state_d.prox_result = scaled_result; // see RULE12
            if (diode_avg >= ssr_pkg::APC_HIGH_MARK &&
                state_q.apc_shift < ssr_pkg::APC_SHIFT_MAX) begin
                state_d.apc_shift = state_q.apc_shift + 3'h1; // see RULE14
            end else if (diode_avg < ssr_pkg::APC_LOW_MARK &&
                         state_q.apc_shift != 3'h0) begin
                state_d.apc_shift = state_q.apc_shift - 3'h1; // see RULE14
            end
        end

        // Read data; the clear low byte comes from the live copy it latches.
        if (reg_rd) begin
            unique case (reg_addr)
                ssr_pkg::ADDR_EVENT_STATUS:
                    state_d.rdata = state_q.event_status; // see RULE1
                ssr_pkg::ADDR_CLEAR_LOW:
                    state_d.rdata = state_q.live_color[0][7:0]; // see RULE10
                ssr_pkg::ADDR_CLEAR_HIGH:
                    state_d.rdata = state_q.latch_color[0][15:8]; // see RULE11
                ssr_pkg::ADDR_RED_LOW:
                    state_d.rdata = state_q.latch_color[1][7:0]; // see RULE11
                ssr_pkg::ADDR_RED_HIGH:
                    state_d.rdata = state_q.latch_color[1][15:8]; // see RULE11
                ssr_pkg::ADDR_GREEN_LOW:
                    state_d.rdata = state_q.latch_color[2][7:0]; // see RULE11
                ssr_pkg::ADDR_GREEN_HIGH:
                    state_d.rdata = state_q.latch_color[2][15:8]; // see RULE11
                ssr_pkg::ADDR_BLUE_LOW:
                    state_d.rdata = state_q.latch_color[3][7:0]; // see RULE11
                ssr_pkg::ADDR_BLUE_HIGH:
                    state_d.rdata = state_q.latch_color[3][15:8]; // see RULE11
                ssr_pkg::ADDR_PROX_LOW:
                    state_d.rdata = state_q.prox_result[7:0]; // see RULE12
                ssr_pkg::ADDR_PROX_HIGH:
                    state_d.rdata =
                        {2'h0, state_q.prox_result[13:8]}; // see RULE12
                ssr_pkg::ADDR_VALID_SAT:
                    state_d.rdata = validity_saturation_status_byte; // see RULE24
                default:
                    state_d.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    // All state resets to constants; no write path exists into the bank.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q.event_status <= ssr_pkg::EVENT_STATUS_RESET;
            state_q.prox_valid <= 1'b0;
            state_q.color_valid <= 1'b0;
            state_q.sat <= ssr_pkg::SAT_RESET;
            state_q.live_color <= '0;
            state_q.latch_color <= '0;
            state_q.prox_result <= 14'h0000;
            state_q.apc_shift <= ssr_pkg::APC_SHIFT_RESET;
            state_q.gesture_mode_q <= 1'b0;
            state_q.prox_en_q <= 1'b0;
            state_q.color_en_q <= 1'b0;
            state_q.rdata <= ssr_pkg::RDATA_RESET;
        end else begin
            state_q <= state_d; // see RULE24
        end
    end

    // Registered outputs.
    assign reg_rdata = state_q.rdata;
    assign event_status = state_q.event_status;

endmodule

//--- dv/ssr_status_regs_sva.sv
// Watches the register bank ports for flag, read and pulse-count rules.
module ssr_status_regs_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    input wire ssr_pkg::ssr_config_type cfg,
    input wire ssr_pkg::ssr_color_in_type color_in,
    input wire ssr_pkg::ssr_prox_in_type prox_in,
    input wire ssr_pkg::ssr_misc_in_type misc_in,
    input wire logic [7:0] status_clear,
    input wire logic [7:0] event_status,
    input wire logic [4:0] prox_pulse_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    a_reserved_zero: assert property (
        (event_status & 8'h09) == 8'h00)
        else $error("reserved event bit set");
    a_color_sat_set: assert property (
        cfg.color_sat_irq_en && (color_in.frontend_saturated
        || color_in.counter_saturated) |=> event_status[7])
        else $error("colour saturation flag missing");
    a_prox_sat_set: assert property (
        cfg.prox_sat_irq_en && (prox_in.reflected_saturated
        || prox_in.ambient_saturated) |=> event_status[6])
        else $error("proximity saturation flag missing");
    a_prox_event_set: assert property (
        cfg.prox_irq_en && prox_in.threshold_event |=> event_status[5])
        else $error("proximity event flag missing");
    a_prox_event_cause: assert property (
        $rose(event_status[5])
        |-> $past(cfg.prox_irq_en && prox_in.threshold_event))
        else $error("proximity event flag without cause");
    a_color_event_set: assert property (
        cfg.color_sat_irq_en && color_in.threshold_event
        |=> event_status[4])
        else $error("colour event flag missing");
    a_gesture_gated: assert property (
        $rose(event_status[2]) |-> $past(cfg.gesture_irq_en))
        else $error("gesture flag while disabled");
    a_calib_set: assert property (
        misc_in.calib_done |=> event_status[1])
        else $error("calibration flag missing");
    a_prox_high_zero: assert property (
        reg_rd && reg_addr == ssr_pkg::ADDR_PROX_HIGH
        |=> reg_rdata[7:6] == 2'b00)
        else $error("proximity high byte upper bits set");
    a_validity_saturation_status_resv: assert property (
        reg_rd && reg_addr == ssr_pkg::ADDR_VALID_SAT |=> !reg_rdata[5])
        else $error("reserved status two bit set");
    a_unmapped_zero: assert property (
        reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_pulse_legal: assert property (
        $onehot(prox_pulse_count) && prox_pulse_count <= 5'h10)
        else $error("illegal pulse count");
    a_pulse_step: assert property (
        !$stable(prox_pulse_count) |-> $past(prox_in.cycle_done))
        else $error("pulse count moved outside a cycle");
    a_hit_window: assert property (
        reg_hit == (reg_addr >= 8'h93 && reg_addr <= 8'h9E))
        else $error("bank hit decode wrong");
    ////////////////////////////////////////
    c_latch_read: cover property (reg_rd && reg_addr == 8'h94);
    c_gesture: cover property (event_status[2]);
    c_one_pulse: cover property (prox_pulse_count == 5'h01);
endmodule

bind ssr_status_regs ssr_status_regs_sva ssr_status_regs_sva_inst (
    .clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .cfg(cfg),
    .color_in(color_in), .prox_in(prox_in), .misc_in(misc_in),
    .status_clear(status_clear), .event_status(event_status),
    .prox_pulse_count(prox_pulse_count)
);

//--- dv/ssr_host_model.sv
// Host side of the byte read port, one strobe per byte.
module ssr_host_model (
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    output logic reg_rd,
    output logic [7:0] reg_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // The port is idle from time zero.
    initial begin
        reg_rd = 1'b0;
        reg_addr = 8'h00;
    end
    // Strobes one address; the byte is taken one cycle after the strobe.
    task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
        @(negedge clock);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(negedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~ad;
        dt = reg_rdata;
    endtask
endmodule

//--- dv/ssr_status_regs_tb_top.sv
module ssr_status_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, reg_rd, reg_hit;
    logic [7:0] reg_addr, reg_rdata, status_clear, event_status, d;
    logic [4:0] prox_pulse_count;
    logic [3:0][15:0] va;
    ssr_pkg::ssr_config_type cfg;
    ssr_pkg::ssr_color_in_type ci;
    ssr_pkg::ssr_prox_in_type pi;
    ssr_pkg::ssr_misc_in_type mi;
    int n_mismatch, n_checks, seed, sh, a;
    // Per event source: flag bits, gating and detail bits.
    localparam logic [7:0] EV[9] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h00,
        8'h20, 8'h10, 8'h02, 8'h02};
    localparam logic [7:0] SAT[9] = '{8'h08, 8'h10, 8'h02, 8'h01, 8'h04,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [8:0] GATED = 9'h16F;
    ////////////////////////////////////////
    ssr_status_regs ssr_status_regs_inst (
        .clock(clock), .rst_n(rst_n), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .cfg(cfg), .color_in(ci), .prox_in(pi), .misc_in(mi),
        .status_clear(status_clear), .event_status(event_status),
        .prox_pulse_count(prox_pulse_count)
    );
    ssr_host_model ssr_host_model_inst (
        .clock(clock), .reg_rdata(reg_rdata), .reg_rd(reg_rd),
        .reg_addr(reg_addr)
    );
    // A 25 ns clock.
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Reads one byte and compares the bits under the mask.
    task automatic rc(input logic [7:0] ad, input logic [7:0] e,
            input logic [7:0] m);
        ssr_host_model_inst.rd(ad, d);
        chk(d & m, e & m);
        if (ad == ssr_pkg::ADDR_EVENT_STATUS) begin
            chk(event_status & m, e & m);
        end
    endtask
    task automatic fire(input int e, input logic v);
        case (e)
            0: ci.frontend_saturated = v;
            1: ci.counter_saturated = v;
            2: pi.reflected_saturated = v;
            3: pi.ambient_saturated = v;
            4: pi.converter_saturated = v;
            5: pi.threshold_event = v;
            6: ci.threshold_event = v;
            7: mi.calib_done = v;
            default: mi.calib_event = {3{v}};
        endcase
    endtask
    // Floor average of the unmasked diodes, zero if all are masked.
    function automatic int avg(input logic [3:0][9:0] v,
            input logic [3:0] m);
        int s, n;
        s = 0;
        n = 0;
        for (int i = 0; i < 4; i++) begin
            if (!m[i]) begin
                s += v[i];
                n++;
            end
        end
        return (n == 0) ? 0 : s / n;
    endfunction
    ////////////////////////////////////////
    // Main sequence: reset, colour, proximity, events, gesture queue.
    initial begin
        seed = 32'hb6b8;
        rst_n = 1'b0;
        cfg = '0;
        ci = '0;
        pi = '0;
        mi = '0;
        status_clear = 8'h00;
        n_mismatch = 0;
        n_checks = 0;
        sh = 0;
        cyc(5);
        rst_n = 1'b1;
        chk({3'h0, prox_pulse_count}, 8'h10);
        rc(8'h93, 8'h00, 8'hFF);
        rc(8'h9E, 8'h00, 8'hFF);
        rc(8'h90, 8'h00, 8'hFF);
        cfg.color_engine_en = 1'b1;
        for (int r = 0; r < 2; r++) begin
            cfg.route_ir_diodes_to_color = r[0];
            for (int i = 0; i < 4; i++) begin
                ci.color[i] = 16'($random(seed));
                ci.ir[i] = 16'($random(seed));
            end
            va = r[0] ? ci.ir : ci.color;
            ci.cycle_done = 1'b1;
            cyc(1);
            ci.cycle_done = 1'b0;
            rc(8'h9E, 8'h40, 8'h40);
            rc(8'h94, va[0][7:0], 8'hFF);
            rc(8'h9E, 8'h00, 8'h40);
            ci.color = ~ci.color;
            ci.ir = ~ci.ir;
            ci.cycle_done = 1'b1;
            cyc(1);
            ci.cycle_done = 1'b0;
            for (int i = 1; i < 8; i++) begin
                rc(8'h94 + 8'(i), va[i / 2][(i % 2) * 8 +: 8],
                    8'hFF);
            end
        end
        cfg.prox_engine_en = 1'b1;
        for (int k = 0; k < 24; k++) begin
            for (int i = 0; i < 4; i++) begin
                pi.adc[i] = (k % 3 == 0) ? 10'h3FF : 10'($random(seed));
            end
            cfg.prox_diode_mask = (k == 5) ? 4'hF : 4'($random(seed));
            pi.cycle_done = 1'b1;
            cyc(1);
            pi.cycle_done = 1'b0;
            a = avg(pi.adc, cfg.prox_diode_mask) << sh;
            rc(8'h9E, 8'h80, 8'h80);
            rc(8'h9C, 8'(a), 8'hFF);
            rc(8'h9D, 8'(a >> 8), 8'hFF);
            rc(8'h9E, 8'h00, 8'h80);
            a = avg(pi.adc, cfg.prox_diode_mask);
            if (a >= 768 && sh < 4) begin
                sh++;
            end else if (a < 192 && sh > 0) begin
                sh--;
            end
            chk({3'h0, prox_pulse_count}, 8'(16 >> sh));
        end
        // Enable rises clear both valid flags.
        pi.cycle_done = 1'b1;
        ci.cycle_done = 1'b1;
        cyc(1);
        pi.cycle_done = 1'b0;
        ci.cycle_done = 1'b0;
        rc(8'h9E, 8'hC0, 8'hC0);
        cfg.prox_engine_en = 1'b0;
        cfg.color_engine_en = 1'b0;
        cyc(1);
        cfg.prox_engine_en = 1'b1;
        cfg.color_engine_en = 1'b1;
        cyc(1);
        rc(8'h9E, 8'h00, 8'h80);
        rc(8'h9E, 8'h00, 8'h40);
        for (int en = 0; en < 2; en++) begin
            cfg.prox_sat_irq_en = en[0];
            cfg.color_sat_irq_en = en[0];
            cfg.prox_irq_en = en[0];
            cfg.calib_func_en = {3{en[0]}};
            for (int e = 0; e < 9; e++) begin
                status_clear = 8'hFF;
                fire(e, 1'b1);
                cyc(1);
                status_clear = 8'h00;
                fire(e, 1'b0);
                rc(8'h93, (GATED[e] && !en[0]) ? 8'h00 : EV[e],
                    8'hFF);
                rc(8'h9E, SAT[e], 8'h1F);
            end
        end
        cfg.gesture_irq_en = 1'b1;
        mi.queue_threshold = 6'h03;
        mi.queue_level = 6'h03;
        cyc(2);
        rc(8'h93, 8'h00, 8'h04);
        mi.queue_level = 6'h04;
        cyc(2);
        rc(8'h93, 8'h04, 8'h04);
        mi.queue_level = 6'h01;
        mi.queue_read = 1'b1;
        cyc(1);
        mi.queue_read = 1'b0;
        mi.queue_level = 6'h00;
        rc(8'h93, 8'h00, 8'h04);
        mi.data_valid = 1'b1;
        mi.mode_active = 1'b1;
        cyc(2);
        mi.mode_active = 1'b0;
        cyc(2);
        rc(8'h93, 8'h04, 8'h04);
        close_out();
    end
    // Cuts a hung run short.
    initial begin
        #500us;
        n_mismatch++;
        close_out();
    end
endmodule
